//--- logic/css_cfg.svh
`ifndef CSS_CFG_SVH
`define CSS_CFG_SVH

// clock select field codes
`define CSS_SEL_DEFAULT 2'h0
`define CSS_SEL_SECONDARY 2'h1
`define CSS_SEL_PRIMARY 2'h2
`define CSS_SEL_INTERNAL 2'h3
`define CSS_SEL_RESET 2'h0

// fast rc postscaler codes
`define CSS_DIV_RESET 3'h6
`define CSS_DIV_LOW_FREQ 3'h0

// primary config codes at or below this value name the internal block
`define CSS_CFG_INTERNAL_MAX 3'h3
`define CSS_CFG_RESET 3'h0

// switch pause: falling edges of the old source, rising edges of the new
`define CSS_OLD_EDGES 2'h2
`define CSS_NEW_EDGES 2'h3
`define CSS_CNT_ZERO 2'h0
`define CSS_CNT_ONE 2'h1

`endif

//--- logic/css_pkg.sv
package css_pkg;

	// clock sources, also the index into the sampled source vector
	typedef enum logic [1:0] {
		CSS_SRC_LOW_RC = 2'h0,
		CSS_SRC_FAST_RC = 2'h1,
		CSS_SRC_PRIMARY = 2'h2,
		CSS_SRC_SECONDARY = 2'h3
	} css_src_t;

	// switch sequencer, one-hot
	typedef enum logic [2:0] {
		CSS_ST_RUN = 3'h1,
		CSS_ST_OLD = 3'h2,
		CSS_ST_NEW = 3'h4
	} css_state_t;

endpackage

//--- logic/css_clock_switch.sv
// How it works
// - two-bit select field picks system clock source
// - new source taken after short transition pause
// - startup flag when primary runs after timer
// - secondary flag while secondary clocks device
// - both status flags never set together
// - both flags clear means internal rc clocking, a pause, or primary before its timer
// - sleep request consults idle select bit
// - secondary refused while its oscillator disabled
// - reset clears select field to configured default
// - fast rc divider resets to 4 MHz code
// - power-up runs from low rc until configured
// - primary config applied only after loading
// - pause two old plus three new cycles
// - two select codes reach the default source
// - secondary oscillator keeps running in sleep
// - low rc clocks watchdog and monitor except during reset
// - internal block may serve as primary oscillator
// - codes: 11 internal, 10 primary, 01 secondary
// - idle select 1 idles, 0 sleeps fully
`timescale 1ns/100ps
`include "css_cfg.svh"

module css_clock_switch (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic src_low_rc,
	input wire logic src_fast_rc,
	input wire logic src_primary,
	input wire logic src_secondary,
	input wire logic config_loaded,
	input wire logic [2:0] primary_osc_config,
	input wire logic startup_timer_expired,
	input wire logic select_write,
	input wire logic [1:0] select_wdata,
	input wire logic divider_write,
	input wire logic [2:0] divider_wdata,
	input wire logic idle_on_sleep_select,
	input wire logic secondary_osc_enable,
	input wire logic sleep_exec,
	output logic sys_clk_out,
	output logic low_rc_feature_clk,
	output logic low_rc_enable,
	output logic secondary_osc_run,
	output logic [1:0] clock_select_field,
	output logic [2:0] fast_rc_divider_select,
	output logic [1:0] active_source,
	output logic switching,
	output logic startup_timer_done_flag,
	output logic secondary_clock_active_flag,
	output logic enter_sleep_pulse,
	output logic enter_idle_pulse,
	output logic select_ignored_pulse
);

	logic [3:0] src_raw;
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic [3:0] sync3_reg;
	logic [3:0] rise;
	logic [3:0] fall;

	// source levels ordered by css_src_t
	assign src_raw = {src_secondary, src_primary, src_fast_rc, src_low_rc};

	// two-stage synchroniser per source plus a third stage for edges;
	// stage one feeds stage two only, so a metastable level never reaches logic
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_sync
			always_ff @(posedge mclk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
					sync3_reg[gi] <= 1'b0;
				end
				else
				begin
					sync1_reg[gi] <= src_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
					sync3_reg[gi] <= sync2_reg[gi];
				end
			end
			assign rise[gi] = sync2_reg[gi] & ~sync3_reg[gi];
			assign fall[gi] = ~sync2_reg[gi] & sync3_reg[gi];
		end
	endgenerate

	// software-visible control state
	logic [1:0] sel_reg, sel_next;
	logic [2:0] div_reg, div_next;
	logic [2:0] cfg_reg, cfg_next;
	logic cfg_loaded_reg, cfg_loaded_next;
	logic sec_run_reg, sec_run_next;

	// select and divider writes; config captured once it has been loaded
	always_comb
	begin
		sel_next = sel_reg;
		div_next = div_reg;
		cfg_next = cfg_reg;
		cfg_loaded_next = cfg_loaded_reg;
		sec_run_next = secondary_osc_enable;
		if (select_write)
			sel_next = select_wdata;
		if (divider_write)
			div_next = divider_wdata;
		if (config_loaded && !cfg_loaded_reg)
		begin
			cfg_next = primary_osc_config;
			cfg_loaded_next = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sel_reg <= `CSS_SEL_RESET;
			div_reg <= `CSS_DIV_RESET;
			cfg_reg <= `CSS_CFG_RESET;
			cfg_loaded_reg <= 1'b0;
			sec_run_reg <= 1'b0;
		end
		else
		begin
			sel_reg <= sel_next;
			div_reg <= div_next;
			cfg_reg <= cfg_next;
			cfg_loaded_reg <= cfg_loaded_next;
			sec_run_reg <= sec_run_next;
		end
	end

	// target source from select, config and divider
	css_pkg::css_src_t internal_src;
	css_pkg::css_src_t primary_src;
	css_pkg::css_src_t target_src;
	logic cfg_is_internal;

	// the internal block uses its low rc output only at the lowest divider code;
	// a code-00 select and a code-10 select reach the same primary source
	always_comb
	begin
		cfg_is_internal = (cfg_reg <= `CSS_CFG_INTERNAL_MAX);
		internal_src = (div_reg == `CSS_DIV_LOW_FREQ) ? css_pkg::CSS_SRC_LOW_RC
			: css_pkg::CSS_SRC_FAST_RC;
		primary_src = cfg_is_internal ? internal_src : css_pkg::CSS_SRC_PRIMARY;
		unique case (sel_reg)
			`CSS_SEL_SECONDARY: target_src = css_pkg::CSS_SRC_SECONDARY;
			`CSS_SEL_INTERNAL: target_src = internal_src;
			`CSS_SEL_PRIMARY: target_src = primary_src;
			`CSS_SEL_DEFAULT: target_src = primary_src;
		endcase
		if (!cfg_loaded_reg)
			target_src = css_pkg::CSS_SRC_LOW_RC;
	end

	// switch sequencer
	css_pkg::css_state_t state_reg, state_next;
	css_pkg::css_src_t active_reg, active_next;
	css_pkg::css_src_t pend_reg, pend_next;
	logic [1:0] cnt_reg, cnt_next;
	logic out_reg, out_next, switch_reg, switch_next;
	logic gated_reg, gated_next;
	logic start_ok;

	// a disabled secondary is never taken, and an external primary is not
	// taken before its start-up timer expires, so the pause sees a stable source
	always_comb
	begin
		start_ok = (target_src != active_reg);
		if (target_src == css_pkg::CSS_SRC_SECONDARY && !secondary_osc_enable)
			start_ok = 1'b0;
		if (target_src == css_pkg::CSS_SRC_PRIMARY && !startup_timer_expired)
			start_ok = 1'b0;
	end

	// old phase: output follows the old source until it first falls, then
	// stays low; new phase: output released on the rising edge that ends
	// the count, so neither end of the pause cuts a pulse short
	always_comb
	begin
		state_next = state_reg;
		active_next = active_reg;
		pend_next = pend_reg;
		cnt_next = cnt_reg;
		gated_next = gated_reg;
		out_next = 1'b0;
		unique case (state_reg)
			css_pkg::CSS_ST_RUN:
			begin
				out_next = sync2_reg[active_reg];
				if (start_ok)
				begin
					state_next = css_pkg::CSS_ST_OLD;
					pend_next = target_src;
					cnt_next = `CSS_CNT_ZERO;
					gated_next = 1'b0;
				end
			end
			css_pkg::CSS_ST_OLD:
			begin
				out_next = sync2_reg[active_reg] & ~gated_reg & ~fall[active_reg];
				if (fall[active_reg])
				begin
					gated_next = 1'b1;
					cnt_next = cnt_reg + `CSS_CNT_ONE;
					if (cnt_reg + `CSS_CNT_ONE == `CSS_OLD_EDGES)
					begin
						state_next = css_pkg::CSS_ST_NEW;
						active_next = pend_reg;
						cnt_next = `CSS_CNT_ZERO;
					end
				end
			end
			css_pkg::CSS_ST_NEW:
			begin
				if (rise[active_reg])
				begin
					cnt_next = cnt_reg + `CSS_CNT_ONE;
					if (cnt_reg + `CSS_CNT_ONE == `CSS_NEW_EDGES)
					begin
						state_next = css_pkg::CSS_ST_RUN;
						out_next = 1'b1;
					end
				end
			end
		endcase
		switch_next = (state_next != css_pkg::CSS_ST_RUN); // registered so the port is glitch-free
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_reg <= css_pkg::CSS_ST_RUN;
			active_reg <= css_pkg::CSS_SRC_LOW_RC;
			pend_reg <= css_pkg::CSS_SRC_LOW_RC;
			cnt_reg <= `CSS_CNT_ZERO;
			gated_reg <= 1'b0;
			out_reg <= 1'b0;
			switch_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			active_reg <= active_next;
			pend_reg <= pend_next;
			cnt_reg <= cnt_next;
			gated_reg <= gated_next;
			out_reg <= out_next;
			switch_reg <= switch_next;
		end
	end

	// status flags and sleep decode
	logic stdone_reg, stdone_next;
	logic sec_reg, sec_next;
	logic sleep_reg, sleep_next;
	logic idle_reg, idle_next;
	logic ign_reg, ign_next;
	logic feat_reg, feat_next, lrc_en_reg, lrc_en_next;

	// flags derive from one active source, so at most one is ever set;
	// with both clear the device is in a pause, runs from an internal rc source, or runs from primary before its timer
	always_comb
	begin
		stdone_next = (state_reg == css_pkg::CSS_ST_RUN) && startup_timer_expired
			&& (active_reg == css_pkg::CSS_SRC_PRIMARY);
		sec_next = (state_reg == css_pkg::CSS_ST_RUN)
			&& (active_reg == css_pkg::CSS_SRC_SECONDARY);
		sleep_next = sleep_exec && !idle_on_sleep_select;
		idle_next = sleep_exec && idle_on_sleep_select;
		ign_next = sleep_exec && !secondary_osc_enable
			&& (sel_reg == `CSS_SEL_SECONDARY);
		feat_next = sync2_reg[css_pkg::CSS_SRC_LOW_RC];
		lrc_en_next = 1'b1; // low rc enabled from the first edge out of reset
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			stdone_reg <= 1'b0;
			sec_reg <= 1'b0;
			sleep_reg <= 1'b0;
			idle_reg <= 1'b0;
			ign_reg <= 1'b0;
			feat_reg <= 1'b0;
			lrc_en_reg <= 1'b0;
		end
		else
		begin
			stdone_reg <= stdone_next;
			sec_reg <= sec_next;
			sleep_reg <= sleep_next;
			idle_reg <= idle_next;
			ign_reg <= ign_next;
			feat_reg <= feat_next;
			lrc_en_reg <= lrc_en_next;
		end
	end

	// outputs, each straight from a flip-flop; low rc is switched off only during reset
	assign sys_clk_out = out_reg;
	assign low_rc_feature_clk = feat_reg;
	assign low_rc_enable = lrc_en_reg;
	assign secondary_osc_run = sec_run_reg;
	assign clock_select_field = sel_reg;
	assign fast_rc_divider_select = div_reg;
	assign active_source = active_reg;
	assign switching = switch_reg;
	assign startup_timer_done_flag = stdone_reg;
	assign secondary_clock_active_flag = sec_reg;
	assign enter_sleep_pulse = sleep_reg;
	assign enter_idle_pulse = idle_reg;
	assign select_ignored_pulse = ign_reg;

	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	a_flags_exclusive: assert property (!(stdone_reg && sec_reg))
		else $error("both status flags set");
	a_sec_flag_source: assert property (
		sec_reg |-> $past(active_reg) == css_pkg::CSS_SRC_SECONDARY)
		else $error("secondary flag without secondary source");
	a_startup_flag_cause: assert property (
		(state_reg == css_pkg::CSS_ST_RUN && active_reg == css_pkg::CSS_SRC_PRIMARY
		&& startup_timer_expired) |=> stdone_reg)
		else $error("startup flag missing on primary");
	a_powerup_low_rc: assert property (
		!cfg_loaded_reg |-> active_reg == css_pkg::CSS_SRC_LOW_RC)
		else $error("left low rc before config loaded");
	a_sleep_full: assert property (
		(sleep_exec && !idle_on_sleep_select) |=> (sleep_reg && !idle_reg))
		else $error("full sleep not entered");
	a_sleep_idle: assert property (
		(sleep_exec && idle_on_sleep_select) |=> (idle_reg && !sleep_reg))
		else $error("idle not entered");
	// a pause towards the secondary may only open while its oscillator is enabled
	a_secondary_refused: assert property (
		(!secondary_osc_enable && state_reg == css_pkg::CSS_ST_RUN)
		|=> !(state_reg == css_pkg::CSS_ST_OLD
		&& pend_reg == css_pkg::CSS_SRC_SECONDARY))
		else $error("disabled secondary selected");
	a_pause_low: assert property (
		(state_reg == css_pkg::CSS_ST_NEW) ##1 (state_reg == css_pkg::CSS_ST_NEW)
		|-> !out_reg)
		else $error("clock not held low in pause");
	a_new_edges: assert property (
		(state_reg == css_pkg::CSS_ST_NEW) ##1 (state_reg == css_pkg::CSS_ST_RUN)
		|-> $past(cnt_reg) == (`CSS_NEW_EDGES - `CSS_CNT_ONE) && out_reg)
		else $error("pause ended on wrong edge count");
	a_old_edges: assert property (
		(state_reg == css_pkg::CSS_ST_OLD) ##1 (state_reg == css_pkg::CSS_ST_NEW)
		|-> $past(cnt_reg) == (`CSS_OLD_EDGES - `CSS_CNT_ONE))
		else $error("old phase ended on wrong edge count");

	c_switch_secondary: cover property (
		state_reg == css_pkg::CSS_ST_NEW && active_reg == css_pkg::CSS_SRC_SECONDARY
		##[1:200] sec_reg);
	c_switch_primary: cover property (
		cfg_loaded_reg && active_reg == css_pkg::CSS_SRC_PRIMARY ##1 stdone_reg);
	c_idle_entry: cover property (idle_reg);
	c_refused: cover property (ign_reg);

endmodule

//--- verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic mclk, reset_n, src_low_rc, src_fast_rc, src_primary, src_secondary;
	logic config_loaded, startup_timer_expired, select_write, divider_write;
	logic idle_on_sleep_select, secondary_osc_enable, sleep_exec;
	logic [2:0] primary_osc_config, divider_wdata, fast_rc_divider_select;
	logic [1:0] select_wdata, clock_select_field, active_source;
	logic sys_clk_out, low_rc_feature_clk, low_rc_enable, secondary_osc_run, switching;
	logic startup_timer_done_flag, secondary_clock_active_flag;
	logic enter_sleep_pulse, enter_idle_pulse, select_ignored_pulse;
	int mismatches, cmp_count, cyc, sw_len, tog;
	logic last_out;
	// rows: select code, secondary enable, expected source, startup flag, secondary flag
	logic [6:0] rows [5] = '{7'h5A, 7'h3D, 7'h74, 7'h1A, 7'h2A};

	css_clock_switch uut (.mclk, .reset_n, .src_low_rc, .src_fast_rc, .src_primary,
		.src_secondary, .config_loaded, .primary_osc_config, .startup_timer_expired,
		.select_write, .select_wdata, .divider_write, .divider_wdata,
		.idle_on_sleep_select, .secondary_osc_enable, .sleep_exec, .sys_clk_out,
		.low_rc_feature_clk, .low_rc_enable, .secondary_osc_run, .clock_select_field,
		.fast_rc_divider_select, .active_source, .switching, .startup_timer_done_flag,
		.secondary_clock_active_flag, .enter_sleep_pulse, .enter_idle_pulse,
		.select_ignored_pulse);

	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// source waves are slow against mclk so the synchronisers see every edge
	always @(posedge mclk)
	begin
		cyc++;
		src_low_rc <= cyc[4];
		src_fast_rc <= cyc[2];
		src_primary <= (cyc % 6) < 3;
		src_secondary <= cyc[3];
		if (cyc == 20000)
		begin
			mismatches++;
			conclude();
		end
	end

	task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic do_reset(input logic [2:0] c);
		@(posedge mclk);
		reset_n <= 1'b0;
		config_loaded <= 1'b0;
		primary_osc_config <= c;
		repeat (20) @(posedge mclk);
		#1;
		chk("sel_rst", clock_select_field, 4'h0);
		chk("div_rst", fast_rc_divider_select, 4'h6);
		chk("src_rst", active_source, 4'h0);
		chk("lrc_en_rst", low_rc_enable, 4'h0);
		@(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		#1;
		chk("lrc_en", low_rc_enable, 4'h1);
		$display("test reset done");
	endtask

	task automatic wr_sel(input logic [1:0] v);
		@(posedge mclk);
		select_write <= 1'b1;
		select_wdata <= v;
		@(posedge mclk);
		select_write <= 1'b0;
		#1;
	endtask

	// waits for the engine to land on the expected source, timing the pause
	task automatic settle(input logic [1:0] exp);
		int n;
		n = 0;
		sw_len = 0;
		while (!(active_source === exp && switching === 1'b0) && n < 400)
		begin
			if (switching === 1'b1)
			begin
				sw_len++;
				last_out = sys_clk_out;
			end
			@(posedge mclk);
			#1;
			n++;
		end
		repeat (3) @(posedge mclk);
		#1;
		chk("src", active_source, {2'h0, exp});
	endtask

	task automatic sleep_chk(input logic i, input logic [2:0] exp);
		@(posedge mclk);
		idle_on_sleep_select <= i;
		sleep_exec <= 1'b1;
		@(posedge mclk);
		sleep_exec <= 1'b0;
		#1;
		chk("pulses", {enter_idle_pulse, enter_sleep_pulse, select_ignored_pulse}, exp);
		$display("test sleep idle=%0d done", i);
	endtask

	initial
	begin
		{reset_n, config_loaded, select_write, divider_write, sleep_exec} = 5'h0;
		{idle_on_sleep_select, secondary_osc_enable} = 2'h0;
		{src_low_rc, src_fast_rc, src_primary, src_secondary} = 4'h0;
		startup_timer_expired = 1'b1;
		primary_osc_config = 3'h4;
		select_wdata = 2'h0;
		divider_wdata = 3'h6;
		{mismatches, cmp_count, cyc} = 0;
		do_reset(3'h4);
		wr_sel(2'h2);
		repeat (100) @(posedge mclk);
		#1;
		chk("src_unloaded", active_source, 4'h0);
		@(posedge mclk);
		config_loaded <= 1'b1;
		settle(2'h2);
		$display("test power-up done");
		foreach (rows[i])
		begin
			@(posedge mclk);
			secondary_osc_enable <= rows[i][4];
			wr_sel(rows[i][6:5]);
			settle(rows[i][3:2]);
			chk("stdone", startup_timer_done_flag, {3'h0, rows[i][1]});
			chk("t1", secondary_clock_active_flag, {3'h0, rows[i][0]});
			chk("osc_run", secondary_osc_run, {3'h0, rows[i][4]});
			if (rows[i][6:5] == 2'h1 && rows[i][4])
			begin
				chk("pause_len", sw_len >= 32, 4'h1);
				chk("pause_out", last_out, 4'h0);
			end
			$display("test row %0d done", i);
		end
		// timer running again: the startup flag drops though primary still clocks
		@(posedge mclk);
		startup_timer_expired <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk("stdone_wait", startup_timer_done_flag, 4'h0);
		@(posedge mclk);
		startup_timer_expired <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		chk("stdone_back", startup_timer_done_flag, 4'h1);
		$display("test startup timer done");
		// select still secondary with its oscillator off: sleep must refuse it
		sleep_chk(1'b1, 3'h5);
		@(posedge mclk);
		secondary_osc_enable <= 1'b1;
		sleep_chk(1'b0, 3'h2);
		tog = 0;
		repeat (64)
		begin
			last_out = low_rc_feature_clk;
			@(posedge mclk);
			#1;
			tog += (low_rc_feature_clk !== last_out);
		end
		chk("feature_clk", tog >= 2, 4'h1);
		$display("test feature clock done");
		do_reset(3'h1);
		@(posedge mclk);
		secondary_osc_enable <= 1'b0;
		config_loaded <= 1'b1;
		settle(2'h1);
		wr_sel(2'h3);
		settle(2'h1);
		chk("flags", {startup_timer_done_flag, secondary_clock_active_flag}, 4'h0);
		@(posedge mclk);
		divider_write <= 1'b1;
		divider_wdata <= 3'h0;
		@(posedge mclk);
		divider_write <= 1'b0;
		#1;
		chk("div", fast_rc_divider_select, 4'h0);
		settle(2'h0);
		$display("test internal block done");
		conclude();
	end
endmodule
